// ---- core/regbank_pkg.sv ----
`default_nettype none
package regbank_pkg;
    localparam int DATA_W = 32;
    localparam int PHYS_GP = 30;
    localparam int SAVED_N = 5;
    localparam logic [3:0] IDX_PC = 4'hf;
    localparam logic [3:0] IDX_FIRST_FAST = 4'h8;
    localparam logic [3:0] IDX_SP = 4'hd;
    localparam logic [3:0] IDX_LINK = 4'he;
    localparam logic [4:0] BASE_FAST = 5'h0f;
    localparam logic [4:0] BASE_SUPV = 5'h16;
    localparam logic [4:0] BASE_ABRT = 5'h18;
    localparam logic [4:0] BASE_NIRQ = 5'h1a;
    localparam logic [4:0] BASE_UNDF = 5'h1c;
    localparam logic [4:0] MODE_USER = 5'h10;
    localparam logic [4:0] MODE_FAST = 5'h11;
    localparam logic [4:0] MODE_NIRQ = 5'h12;
    localparam logic [4:0] MODE_SUPV = 5'h13;
    localparam logic [4:0] MODE_ABRT = 5'h17;
    localparam logic [4:0] MODE_UNDF = 5'h1b;
    localparam logic [4:0] MODE_SYST = 5'h1f;
    localparam int MODE_MSB = 4;
    localparam int CTRL_LSB = 8;
    localparam int STAT_T_BIT = 5;
    localparam int STAT_J_BIT = 24;
    localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] EXC_RET_OFFSET = 32'h0000_0004;
    localparam logic [5:0] LEN_WORD = 6'h20;
    localparam logic [5:0] LEN_HALF = 6'h10;
    localparam logic [5:0] LEN_BYTE = 6'h08;
    localparam logic [31:0] MASK_HALF = 32'h0000_ffff;
    localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_PC = 32'h0000_0008;
    localparam int CTRL_BIG_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ISA_WORD, ISA_HALF, ISA_BYTE} isa_type;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_type;
    typedef enum logic [2:0] {
        OP_BRANCH_WITH_LINK, OP_BRANCH_EXCHANGE_STATE, OP_BRANCH_LINK_EXCHANGE_STATE,
        OP_BRANCH_TO_BYTECODE_STATE, OP_EXC_RETURN, OP_STATUS_WRITE, OP_SAVED_WRITE
    } op_type;
    typedef enum logic [2:0] {
        EXC_FAST_IRQ, EXC_IRQ, EXC_PREFETCH_ABORT, EXC_DATA_ABORT, EXC_UNDEFINED, EXC_SOFTWARE
    } exc_kind_type;

    typedef struct packed {logic user; logic [3:0] idx_a; logic [3:0] idx_b;} rd_req_type;
    typedef struct packed {logic valid; logic user; logic [3:0] idx; logic [31:0] data;} wr_req_type;
    typedef struct packed {logic valid; op_type op; logic [31:0] arg;} cmd_type;
    typedef struct packed {logic valid; exc_kind_type kind; logic [31:0] vector;} exc_type;
    typedef struct packed {
        size_type size; logic [1:0] off; logic [31:0] wdata; logic [31:0] rdata;
    } mem_req_type;
    typedef struct packed {
        logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [31:0] araddr; logic rready;
    } axi_in_type;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } axi_out_type;
endpackage : regbank_pkg
`default_nettype wire

// ---- core/banked_register_file.sv ----
// What this block does
// - Holds 31 general 32-bit registers and 6 status words, 37 in total.
// - Sixteen indices are visible at once plus current and, in the five exception modes, saved word.
// - Fast-interrupt mode swaps in private registers for indices 8 to 14.
// - Supervisor, abort, interrupt and undefined modes bank indices 13 and 14.
// - System mode uses the user bank; the user bank is reachable on request.
// - Branch with link copies the program counter into index 14.
// - Exception entry loads the new mode's index 14 with the return value.
// - Each exception mode has a saved word captured at entry.
// - Program counter is word, halfword or byte aligned by instruction state.
// - Compact state picks the fetched halfword with program counter bit 1.
// - Bytecode state always fetches whole aligned words.
// - Changing instruction state keeps mode and register contents.
// - Exceptions force the 32-bit state; return restores the previous state.
// - Exchange branches, and program counter loads outside bytecode state, switch 32/16; bytecode branch only.
// - Memory is bytes numbered upward; bytes 0 to 3 form the first word.
// - Big-endian places byte 0 on data lines 31 to 24.
// - Little-endian places byte 0 on data lines 7 to 0.
// - Instructions are 32, 16 or a multiple of 8 bits long by state.
// - Seven operating modes exist; all except user are privileged.
// - Aborts enter abort mode; undefined instructions enter undefined mode.
// - One current status word holds flags and mode bits in all modes.
// - One current and five saved status words are implemented.
// - Unused status bits are readable and writable.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`default_nettype none
module banked_register_file (
    input wire logic CLK,
    input wire logic RSTN,
    input wire regbank_pkg::rd_req_type RD,
    input wire regbank_pkg::wr_req_type WR,
    input wire regbank_pkg::cmd_type CMD,
    input wire regbank_pkg::exc_type EXC,
    input wire regbank_pkg::mem_req_type MEM,
    input wire logic [31:0] IFETCH_DATA,
    input wire regbank_pkg::axi_in_type AXI_IN,
    output logic [31:0] RD_A_DATA,
    output logic [31:0] RD_B_DATA,
    output logic [31:0] CUR_STATUS,
    output logic [31:0] SAVED_STATUS,
    output logic [31:0] FETCH_ADDR,
    output logic [31:0] INSTR,
    output logic [5:0] INSTR_LEN,
    output logic [31:0] MEM_WDATA,
    output logic [31:0] LOAD_DATA,
    output regbank_pkg::axi_out_type AXI_OUT
);
    import regbank_pkg::*;

    typedef struct packed {
        logic [PHYS_GP-1:0][31:0] gp;
        logic [31:0] pc;
        logic [31:0] cur;
        logic [SAVED_N-1:0][31:0] saved;
        logic big_endian;
        logic [31:0] rd_a;
        logic [31:0] rd_b;
        logic [31:0] saved_out;
        logic [31:0] fetch_addr;
        logic [31:0] instr;
        logic [5:0] instr_len;
        logic [31:0] mem_wdata;
        logic [31:0] load_data;
        logic aw_have;
        logic [31:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        axi_out_type axo;
    } state_type;

    state_type s_q;
    state_type s_d;

    function automatic logic [4:0] phys_of(input logic [3:0] idx, input logic [4:0] mode,
                                           input logic user);
        logic [4:0] base;
        base = 5'h00;
        phys_of = {1'b0, idx};
        if (!user) begin
            case (mode)
                MODE_FAST: base = BASE_FAST;
                MODE_SUPV: base = BASE_SUPV;
                MODE_ABRT: base = BASE_ABRT;
                MODE_NIRQ: base = BASE_NIRQ;
                MODE_UNDF: base = BASE_UNDF;
                default: base = 5'h00;
            endcase
            if (mode == MODE_FAST && idx >= IDX_FIRST_FAST && idx != IDX_PC) begin
                phys_of = base + 5'(idx - IDX_FIRST_FAST);
            end else if (base != 5'h00 && idx >= IDX_SP && idx != IDX_PC) begin
                phys_of = base + 5'(idx - IDX_SP);
            end
        end
    endfunction : phys_of

    function automatic logic [2:0] slot_of(input logic [4:0] mode);
        case (mode)
            MODE_FAST: slot_of = 3'h0;
            MODE_SUPV: slot_of = 3'h1;
            MODE_ABRT: slot_of = 3'h2;
            MODE_NIRQ: slot_of = 3'h3;
            MODE_UNDF: slot_of = 3'h4;
            default: slot_of = 3'h7;
        endcase
    endfunction : slot_of

    function automatic logic [4:0] mode_of_exc(input exc_kind_type kind);
        case (kind)
            EXC_FAST_IRQ: mode_of_exc = MODE_FAST;
            EXC_IRQ: mode_of_exc = MODE_NIRQ;
            EXC_PREFETCH_ABORT: mode_of_exc = MODE_ABRT;
            EXC_DATA_ABORT: mode_of_exc = MODE_ABRT;
            EXC_UNDEFINED: mode_of_exc = MODE_UNDF;
            default: mode_of_exc = MODE_SUPV;
        endcase
    endfunction : mode_of_exc

    function automatic isa_type isa_of(input logic [31:0] st);
        if (st[STAT_J_BIT]) begin
            isa_of = ISA_BYTE;
        end else if (st[STAT_T_BIT]) begin
            isa_of = ISA_HALF;
        end else begin
            isa_of = ISA_WORD;
        end
    endfunction : isa_of

    function automatic logic [31:0] with_isa(input logic [31:0] st, input isa_type isa);
        with_isa = st;
        with_isa[STAT_T_BIT] = (isa == ISA_HALF);
        with_isa[STAT_J_BIT] = (isa == ISA_BYTE);
    endfunction : with_isa

    function automatic logic [31:0] align_pc(input logic [31:0] v, input isa_type isa);
        align_pc = v;
        case (isa)
            ISA_WORD: align_pc[1:0] = 2'h0;
            ISA_HALF: align_pc[0] = 1'b0;
            default: align_pc = v;
        endcase
    endfunction : align_pc

    // Bit shift of the byte lane a quantity of the given size at the given offset occupies.
    function automatic logic [4:0] lane_shift(input logic big, input size_type size,
                                              input logic [1:0] off);
        logic [1:0] lane;
        lane = off;
        if (big) begin
            case (size)
                SZ_BYTE: lane = 2'(2'h3 - off);
                SZ_HALF: lane = 2'(2'h2 - off);
                default: lane = 2'h0;
            endcase
        end
        lane_shift = {lane, 3'h0};
    endfunction : lane_shift

    function automatic logic [31:0] size_mask(input size_type size);
        case (size)
            SZ_BYTE: size_mask = MASK_BYTE;
            SZ_HALF: size_mask = MASK_HALF;
            default: size_mask = 32'hffff_ffff;
        endcase
    endfunction : size_mask

    function automatic logic [31:0] read_port(input logic [3:0] idx, input logic user);
        if (idx == IDX_PC) begin
            read_port = s_q.pc;
        end else begin
            read_port = s_q.gp[phys_of(idx, s_q.cur[MODE_MSB:0], user)];
        end
    endfunction : read_port

    always_comb begin
        logic [4:0] mode;
        logic [4:0] new_mode;
        isa_type isa;
        logic [31:0] pc_n;
        logic [4:0] sh;
        s_d = s_q;
        mode = s_q.cur[MODE_MSB:0];
        new_mode = mode;
        isa = isa_of(s_q.cur);
        pc_n = s_q.pc;
        sh = 5'h00;

        s_d.rd_a = read_port(RD.idx_a, RD.user);
        s_d.rd_b = read_port(RD.idx_b, RD.user);
        s_d.saved_out = 32'h0000_0000;
        if (slot_of(mode) < 3'(SAVED_N)) begin
            s_d.saved_out = s_q.saved[slot_of(mode)];
        end

        if (WR.valid) begin
            if (WR.idx == IDX_PC) begin
                if (isa != ISA_BYTE) begin
                    isa = WR.data[0] ? ISA_HALF : ISA_WORD;
                end
                pc_n = WR.data;
            end else begin
                s_d.gp[phys_of(WR.idx, mode, WR.user)] = WR.data;
            end
        end

        // A command in the same cycle as a port write to the same index wins.
        if (CMD.valid) begin
            case (CMD.op)
                OP_BRANCH_WITH_LINK: begin
                    s_d.gp[phys_of(IDX_LINK, mode, 1'b0)] = s_q.pc;
                    pc_n = CMD.arg;
                end
                OP_BRANCH_EXCHANGE_STATE: begin
                    isa = CMD.arg[0] ? ISA_HALF : ISA_WORD;
                    pc_n = CMD.arg;
                end
                OP_BRANCH_LINK_EXCHANGE_STATE: begin
                    s_d.gp[phys_of(IDX_LINK, mode, 1'b0)] = s_q.pc;
                    isa = CMD.arg[0] ? ISA_HALF : ISA_WORD;
                    pc_n = CMD.arg;
                end
                OP_BRANCH_TO_BYTECODE_STATE: begin
                    isa = ISA_BYTE;
                    pc_n = CMD.arg;
                end
                OP_EXC_RETURN: begin
                    if (slot_of(mode) < 3'(SAVED_N)) begin
                        s_d.cur = s_q.saved[slot_of(mode)];
                        isa = isa_of(s_q.saved[slot_of(mode)]);
                    end
                    pc_n = CMD.arg;
                end
                OP_STATUS_WRITE: begin
                    // State bits stay put so a status write never strands the fetch logic.
                    if (mode != MODE_USER) begin
                        s_d.cur = CMD.arg;
                    end else begin
                        s_d.cur[31:CTRL_LSB] = CMD.arg[31:CTRL_LSB];
                    end
                end
                OP_SAVED_WRITE: begin
                    if (slot_of(mode) < 3'(SAVED_N)) begin
                        s_d.saved[slot_of(mode)] = CMD.arg;
                    end
                end
                default: begin
                end
            endcase
        end

        if (EXC.valid) begin
            new_mode = mode_of_exc(EXC.kind);
            s_d.saved[slot_of(new_mode)] = s_q.cur;
            s_d.gp[phys_of(IDX_LINK, new_mode, 1'b0)] = s_q.pc + EXC_RET_OFFSET;
            s_d.cur = s_q.cur;
            s_d.cur[MODE_MSB:0] = new_mode;
            isa = ISA_WORD;
            pc_n = EXC.vector;
        end

        s_d.cur = with_isa(s_d.cur, isa);
        s_d.pc = align_pc(pc_n, isa);

        s_d.fetch_addr = {s_d.pc[31:2], 2'h0};
        case (isa_of(s_q.cur))
            ISA_HALF: begin
                sh = lane_shift(s_q.big_endian, SZ_HALF, {s_q.pc[1], 1'b0});
                s_d.instr = (IFETCH_DATA >> sh) & MASK_HALF;
                s_d.instr_len = LEN_HALF;
            end
            ISA_BYTE: begin
                sh = lane_shift(s_q.big_endian, SZ_BYTE, s_q.pc[1:0]);
                s_d.instr = (IFETCH_DATA >> sh) & MASK_BYTE;
                s_d.instr_len = LEN_BYTE;
            end
            default: begin
                s_d.instr = IFETCH_DATA;
                s_d.instr_len = LEN_WORD;
            end
        endcase

        // Misaligned offsets are not corrected; the issuer keeps accesses aligned.
        sh = lane_shift(s_q.big_endian, MEM.size, MEM.off);
        s_d.mem_wdata = (MEM.wdata & size_mask(MEM.size)) << sh;
        s_d.load_data = (MEM.rdata >> sh) & size_mask(MEM.size);

        if (AXI_IN.awvalid && s_q.axo.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = AXI_IN.awaddr;
        end
        if (AXI_IN.wvalid && s_q.axo.wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = AXI_IN.wdata;
            s_d.w_strb = AXI_IN.wstrb;
        end
        if (s_q.axo.bvalid && AXI_IN.bready) begin
            s_d.axo.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.axo.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.axo.bvalid = 1'b1;
            s_d.axo.bresp = RESP_OKAY;
            if (s_q.aw_addr == ADDR_CTRL) begin
                if (s_q.w_strb[0]) begin
                    s_d.big_endian = s_q.w_data[CTRL_BIG_BIT];
                end
            end else if (s_q.aw_addr != ADDR_STATUS && s_q.aw_addr != ADDR_PC) begin
                s_d.axo.bresp = RESP_SLVERR;
            end
        end
        s_d.axo.awready = !s_d.aw_have && !s_d.axo.bvalid;
        s_d.axo.wready = !s_d.w_have && !s_d.axo.bvalid;

        if (s_q.axo.rvalid && AXI_IN.rready) begin
            s_d.axo.rvalid = 1'b0;
        end
        if (AXI_IN.arvalid && s_q.axo.arready) begin
            s_d.axo.rvalid = 1'b1;
            s_d.axo.rresp = RESP_OKAY;
            case (AXI_IN.araddr)
                ADDR_CTRL: s_d.axo.rdata = 32'(s_q.big_endian);
                ADDR_STATUS: s_d.axo.rdata = s_q.cur;
                ADDR_PC: s_d.axo.rdata = s_q.pc;
                default: begin
                    s_d.axo.rdata = 32'h0000_0000;
                    s_d.axo.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_d.axo.arready = !s_d.axo.rvalid;
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '0;
            s_q.pc <= PC_RESET;
            s_q.cur <= STATUS_RESET;
            s_q.axo.awready <= 1'b1;
            s_q.axo.wready <= 1'b1;
            s_q.axo.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign RD_A_DATA = s_q.rd_a;
    assign RD_B_DATA = s_q.rd_b;
    assign CUR_STATUS = s_q.cur;
    assign SAVED_STATUS = s_q.saved_out;
    assign FETCH_ADDR = s_q.fetch_addr;
    assign INSTR = s_q.instr;
    assign INSTR_LEN = s_q.instr_len;
    assign MEM_WDATA = s_q.mem_wdata;
    assign LOAD_DATA = s_q.load_data;
    assign AXI_OUT = s_q.axo;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    a_pc_word_align: assert property (!s_q.cur[STAT_T_BIT] && !s_q.cur[STAT_J_BIT]
        |-> s_q.pc[1:0] == 2'h0) else $error("pc misaligned in word state");
    a_fetch_whole_word: assert property (FETCH_ADDR[1:0] == 2'h0)
        else $error("fetch address not word aligned");
    a_exc_forces_word: assert property (EXC.valid |=> !s_q.cur[STAT_T_BIT]
        && !s_q.cur[STAT_J_BIT] && s_q.cur[MODE_MSB:0] == mode_of_exc($past(EXC.kind)))
        else $error("exception entry state or mode wrong");
    a_exc_link_value: assert property (EXC.valid |=> s_q.gp[phys_of(IDX_LINK,
        s_q.cur[MODE_MSB:0], 1'b0)] == $past(s_q.pc) + EXC_RET_OFFSET)
        else $error("exception link value wrong");
    a_exc_saved_word: assert property (EXC.valid
        |=> s_q.saved[slot_of(s_q.cur[MODE_MSB:0])] == $past(s_q.cur))
        else $error("saved word not captured");
    a_link_copy: assert property (CMD.valid && CMD.op == OP_BRANCH_WITH_LINK
        && !EXC.valid |=> s_q.gp[phys_of(IDX_LINK, s_q.cur[MODE_MSB:0], 1'b0)] == $past(s_q.pc))
        else $error("link register not loaded");
    a_state_keeps_mode: assert property (CMD.op == OP_BRANCH_TO_BYTECODE_STATE
        && CMD.valid && !EXC.valid && !WR.valid
        |=> $stable(s_q.cur[MODE_MSB:0]) && $stable(s_q.gp)) else $error("registers changed");
    a_big_lane_zero: assert property (s_q.big_endian && MEM.size == SZ_BYTE
        && MEM.off == 2'h0 |=> MEM_WDATA[31:24] == $past(MEM.wdata[7:0]))
        else $error("big-endian byte 0 lane wrong");
    a_little_lane_zero: assert property (!s_q.big_endian && MEM.size == SZ_BYTE
        && MEM.off == 2'h0 |=> MEM_WDATA[7:0] == $past(MEM.wdata[7:0]))
        else $error("little-endian byte 0 lane wrong");
    a_axi_b_hold: assert property (AXI_OUT.bvalid && !AXI_IN.bready |=> AXI_OUT.bvalid)
        else $error("write response dropped early");

    c_exception_entry: cover property (EXC.valid ##1 CMD.valid && CMD.op == OP_EXC_RETURN);
    c_bytecode_branch: cover property (CMD.valid && CMD.op == OP_BRANCH_TO_BYTECODE_STATE);
    c_fast_bank_write: cover property (WR.valid && s_q.cur[MODE_MSB:0] == MODE_FAST);
    c_axi_write: cover property (AXI_OUT.bvalid && AXI_IN.bready);
endmodule : banked_register_file
`default_nettype wire

// ---- testbench/pipe_partner.sv ----
`default_nettype none
module pipe_partner #(
    parameter logic [31:0] WORD = 32'h1122_3344
) (
    input wire logic [31:0] fetch_addr,
    output logic [31:0] ifetch_data,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each half of a fetched word differs, so a wrong half select shows.
    always_comb ifetch_data = {~fetch_addr[15:0], fetch_addr[15:0]};
    // Every byte lane of the data bus differs, so a lane swap shows.
    always_comb mem_rdata = WORD;
endmodule : pipe_partner
`default_nettype wire

// ---- testbench/banked_register_file_tb.sv ----
`default_nettype none
module banked_register_file_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import regbank_pkg::*;
    typedef struct packed {logic [3:0] k; logic [33:0] v;} note_type;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    rd_req_type rd = '0;
    wr_req_type wr = '0;
    cmd_type cmd = '0;
    exc_type exc = '0;
    size_type m_size = SZ_WORD;
    logic [1:0] m_off = 2'h0;
    mem_req_type mem;
    axi_in_type axi_in = '0;
    axi_out_type axi_out;
    logic [31:0] rda, rdb, cur, sav, faddr, instr, mwd, ld, fdata, mrd, a8, b13, f8;
    logic [31:0] v[5];
    logic [5:0] ilen;
    logic chk = 1'h0;
    logic age = 1'h0;
    int n_errors = 0;
    int checked = 0;
    note_type notes[$];
    logic [4:0] md[5] = '{MODE_FAST, MODE_NIRQ, MODE_SUPV, MODE_ABRT, MODE_UNDF};
    exc_kind_type ek[6] = '{EXC_DATA_ABORT, EXC_PREFETCH_ABORT, EXC_UNDEFINED, EXC_FAST_IRQ,
        EXC_IRQ, EXC_SOFTWARE};
    logic [4:0] em[6] = '{MODE_ABRT, MODE_ABRT, MODE_UNDF, MODE_FAST, MODE_NIRQ, MODE_SUPV};
    size_type lz[6] = '{SZ_BYTE, SZ_HALF, SZ_BYTE, SZ_BYTE, SZ_HALF, SZ_WORD};
    logic [1:0] lo[6] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h2, 2'h0};
    logic [31:0] lv[6] = '{32'h0000_0033, 32'h0000_1122, 32'h0000_0044,
        32'h0000_0011, 32'h0000_3344, 32'h1122_3344};
    logic [31:0] sv[6] = '{32'h0000_ab00, 32'h00ab_0000, 32'h0000_00ab,
        32'hab00_0000, 32'h0000_00ab, 32'h0000_00ab};
    always #50 clk = ~clk;
    assign mem = {m_size, m_off, 32'h0000_00ab, mrd};
    pipe_partner i_pipe_partner (.fetch_addr(faddr), .ifetch_data(fdata), .mem_rdata(mrd));
    banked_register_file i_banked_register_file (.CLK(clk), .RSTN(rstn), .RD(rd), .WR(wr),
        .CMD(cmd), .EXC(exc), .MEM(mem), .IFETCH_DATA(fdata), .AXI_IN(axi_in),
        .RD_A_DATA(rda), .RD_B_DATA(rdb), .CUR_STATUS(cur), .SAVED_STATUS(sav),
        .FETCH_ADDR(faddr), .INSTR(instr), .INSTR_LEN(ilen), .MEM_WDATA(mwd),
        .LOAD_DATA(ld), .AXI_OUT(axi_out));
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [33:0] pick(input logic [3:0] k);
        case (k)
            4'h0: return {2'h0, rda};
            4'h1: return {2'h0, cur & 32'h0100_003f};
            4'h2: return {2'h0, sav};
            4'h3: return {2'h0, ld};
            4'h6: return {2'h0, faddr};
            4'h7: return {28'h0, ilen};
            4'h8: return {2'h0, rdb};
            4'h9: return {2'h0, mwd};
            default: return {2'h0, instr & MASK_HALF};
        endcase
    endfunction : pick
    // Registered outputs settle one edge after the request, so they are read at the fall.
    always @(posedge clk) age <= chk;
    always @(negedge clk) begin
        if (age) begin
            check(pick(notes[0].k), notes[0].v);
            void'(notes.pop_front());
        end
    end
    always @(posedge clk) begin
        if (axi_out.rvalid && axi_in.rready) begin
            check({axi_out.rresp, axi_out.rdata}, notes[0].v);
            void'(notes.pop_front());
        end
        if (axi_out.bvalid && axi_in.bready) begin
            check({32'h0, axi_out.bresp}, notes[0].v);
            void'(notes.pop_front());
        end
    end
    task automatic note(input logic [3:0] k, input logic [31:0] x);
        notes.push_back('{k, {2'h0, x}});
        chk <= 1'h1;
        @(posedge clk);
        chk <= 1'h0;
        @(posedge clk);
    endtask : note
    task automatic rdr(input logic [3:0] i, input logic u, input logic [31:0] x);
        rd <= '{u, i, i};
        note(4'h0, x);
    endtask : rdr
    task automatic wrr(input logic [3:0] i, input logic [31:0] x);
        wr <= '{1'h1, 1'h0, i, x};
        @(posedge clk);
        wr.valid <= 1'h0;
        @(posedge clk);
    endtask : wrr
    task automatic op(input op_type o, input logic [31:0] a);
        cmd <= '{1'h1, o, a};
        @(posedge clk);
        cmd.valid <= 1'h0;
        @(posedge clk);
    endtask : op
    task automatic ex(input exc_kind_type k);
        exc <= '{1'h1, k, 32'h0000_0040};
        @(posedge clk);
        exc.valid <= 1'h0;
        @(posedge clk);
    endtask : ex
    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        notes.push_back('{4'h5, {32'h0, r}});
        axi_in.awvalid <= 1'h1;
        axi_in.awaddr <= a;
        axi_in.wvalid <= 1'h1;
        axi_in.wdata <= d;
        axi_in.wstrb <= 4'hf;
        axi_in.bready <= 1'h1;
        do begin
            @(posedge clk);
            if (axi_out.awready) axi_in.awvalid <= 1'h0;
            if (axi_out.wready) axi_in.wvalid <= 1'h0;
        end while (!axi_out.bvalid);
        axi_in.bready <= 1'h0;
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [31:0] a, input logic [33:0] x);
        notes.push_back('{4'h5, x});
        axi_in.arvalid <= 1'h1;
        axi_in.araddr <= a;
        axi_in.rready <= 1'h1;
        do begin
            @(posedge clk);
            if (axi_out.arready) axi_in.arvalid <= 1'h0;
        end while (!axi_out.rvalid);
        axi_in.rready <= 1'h0;
        @(posedge clk);
    endtask : axr
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h8c6e));
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        axr(ADDR_STATUS, {RESP_OKAY, STATUS_RESET});
        axr(32'h0000_0010, {RESP_SLVERR, 32'h0000_0000});
        axw(32'h0000_0010, 32'h0000_0001, RESP_SLVERR);
        op(OP_STATUS_WRITE, 32'h00f0_00d3);
        axr(ADDR_STATUS, {RESP_OKAY, 32'h00f0_00d3});
        $display("status test done");
        a8 = $urandom();
        b13 = $urandom();
        f8 = $urandom();
        op(OP_STATUS_WRITE, {27'h0, MODE_SYST});
        wrr(IDX_FIRST_FAST, a8);
        wrr(IDX_SP, b13);
        for (int i = 0; i < 5; i++) begin
            v[i] = $urandom();
            op(OP_STATUS_WRITE, {27'h0, md[i]});
            wrr(IDX_SP, v[i]);
            if (i == 0) wrr(IDX_FIRST_FAST, f8);
        end
        for (int i = 0; i < 5; i++) begin
            op(OP_STATUS_WRITE, {27'h0, md[i]});
            note(4'h1, {27'h0, md[i]});
            rdr(IDX_SP, 1'h0, v[i]);
            rdr(IDX_FIRST_FAST, 1'h0, (i == 0) ? f8 : a8);
            rdr(IDX_SP, 1'h1, b13);
        end
        op(OP_STATUS_WRITE, {27'h0, MODE_SYST});
        rdr(IDX_SP, 1'h0, b13);
        $display("banking test done");
        op(OP_STATUS_WRITE, 32'h0000_00d3);
        op(OP_BRANCH_WITH_LINK, 32'h0000_0200);
        op(OP_BRANCH_WITH_LINK, 32'h0000_0302);
        rdr(IDX_LINK, 1'h0, 32'h0000_0200);
        axr(ADDR_PC, {RESP_OKAY, 32'h0000_0300});
        op(OP_BRANCH_EXCHANGE_STATE, 32'h0000_0103);
        note(4'h1, 32'h0000_0033);
        note(4'h4, 32'h0000_feff);
        for (int i = 0; i < 6; i++) begin
            ex(ek[i]);
            note(4'h1, {27'h0, em[i]});
            note(4'h2, 32'h0000_00f3);
            rdr(IDX_LINK, 1'h0, 32'h0000_0106);
            op(OP_EXC_RETURN, 32'h0000_0102);
            note(4'h1, 32'h0000_0033);
        end
        op(OP_SAVED_WRITE, 32'h0a00_0f13);
        note(4'h2, 32'h0a00_0f13);
        op(OP_BRANCH_TO_BYTECODE_STATE, 32'h0000_0207);
        note(4'h1, 32'h0100_0013);
        note(4'h6, 32'h0000_0204);
        note(4'h7, {26'h0, LEN_BYTE});
        note(4'h4, 32'h0000_00fd);
        wrr(IDX_PC, 32'h0000_0305);
        note(4'h1, 32'h0100_0013);
        op(OP_BRANCH_LINK_EXCHANGE_STATE, 32'h0000_0400);
        rdr(IDX_LINK, 1'h0, 32'h0000_0305);
        note(4'h8, 32'h0000_0305);
        note(4'h7, {26'h0, LEN_WORD});
        note(4'h1, 32'h0000_0013);
        $display("branch and exception test done");
        for (int i = 0; i < 6; i++) begin
            if (i == 3) axw(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
            m_size <= lz[i];
            m_off <= lo[i];
            note(4'h3, lv[i]);
            note(4'h9, sv[i]);
        end
        axr(ADDR_CTRL, {RESP_OKAY, 32'h0000_0001});
        $display("lane test done");
        finish_test();
    end
endmodule : banked_register_file_tb
`default_nettype wire
